// file: btwc_pkg.sv
/*
 * Constants for the belt tension wear check: register indices, field
 * positions, reset values and encodings of the selection fields.
 * Assumes a plain register port with word indices and 16-bit data.
 */
`default_nettype none

package btwc_pkg;

	// Register indices on the register port
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_TENSION_FITTED = 4'h1;
	localparam logic [3:0] ADDR_TENSION_STRETCHED = 4'h2;
	localparam logic [3:0] ADDR_FRICTION_FITTED = 4'h3;
	localparam logic [3:0] ADDR_FRICTION_STRETCHED = 4'h4;
	localparam logic [3:0] ADDR_TENSION_LIMIT = 4'h5;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
	localparam logic [3:0] ADDR_STATE = 4'h8;
	localparam logic [3:0] ADDR_TENSION_EST = 4'h9;
	localparam logic [3:0] ADDR_FRICTION_BASIS = 4'hA;

	// Control register fields
	localparam int CTRL_FUNC_LSB = 0;
	localparam int CTRL_SRC_LSB = 4;

	// State register bit positions
	localparam int STATE_PRED_BIT = 0;
	localparam int STATE_EST_BIT = 1;
	localparam int STATE_WARN_BIT = 2;
	localparam int STATE_TENS_BAD_BIT = 3;
	localparam int STATE_FRIC_BAD_BIT = 4;

	// Interrupt status bit positions
	localparam int IRQ_WARN_SET_BIT = 0;
	localparam int IRQ_WARN_CLR_BIT = 1;
	localparam int IRQ_CFG_BAD_BIT = 2;
	localparam int IRQ_BITS = 3;

	// Reset values
	localparam logic [15:0] PARAM_RESET = 16'h0000;
	localparam logic [2:0] IRQ_RESET = 3'h0;

	// Limit is in 0.1 percent units: full scale is 1000
	localparam logic [9:0] PER_MILLE = 10'h3E8;

	// Function selection
	typedef enum logic [1:0] {
		BTWC_FUNC_OFF,
		BTWC_FUNC_ESTIMATE,
		BTWC_FUNC_PREDICT,
		BTWC_FUNC_RSVD
	} btwc_func_e;

	// Friction source selection
	typedef enum logic [1:0] {
		BTWC_SRC_FORWARD,
		BTWC_SRC_REVERSE,
		BTWC_SRC_AVERAGE,
		BTWC_SRC_RSVD
	} btwc_src_e;

endpackage : btwc_pkg

`default_nettype wire

// file: btwc_top.sv
/*
 * Belt tension wear check: parameter registers, consistency checks,
 * friction basis selection and tension warning with interrupt.
 * Also holds the small reference register used once per parameter.
 * Assumes estimator inputs are synchronous to mclk_in and that the
 * register master follows the one-cycle strobe protocol.
 */
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module btwc_param_reg #(
	parameter int WIDTH = 16,
	parameter logic [3:0] INDEX = 4'h0
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// Write side of the register port
	input wire logic [3:0] addr_in,
	input wire logic [WIDTH-1:0] wdata_in,
	input wire logic wr_in,
	// Stored value
	output logic [WIDTH-1:0] value_out
);

	// Refuse widths the register port cannot carry
	if (WIDTH < 1 || WIDTH > 16)
	begin : g_bad_width
		$error("btwc_param_reg: WIDTH must lie between 1 and 16");
	end

	// Load on a write to this index, zero after reset
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			value_out <= btwc_pkg::PARAM_RESET[WIDTH-1:0];
		else if (wr_in && addr_in == INDEX)
			value_out <= wdata_in;
	end

endmodule : btwc_param_reg

module btwc_top #(
	parameter int DATA_W = 16
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// Register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	// Friction estimator results, 0.1 percent units
	input wire logic [DATA_W-1:0] friction_fwd_in,
	input wire logic [DATA_W-1:0] friction_rev_in,
	input wire logic friction_valid_in,
	// Tension estimator result, 0.1 N units
	input wire logic [DATA_W-1:0] tension_est_in,
	input wire logic tension_valid_in,
	// Status towards the drive
	output logic estimation_enable_out,
	output logic prediction_enable_out,
	output logic [DATA_W-1:0] friction_basis_out,
	output logic machine_diagnosis_warning_out,
	output logic irq_out
);

	// Refuse widths the register port and the limit test cannot carry
	if (DATA_W < 11 || DATA_W > 16)
	begin : g_bad_width
		$error("btwc_top: DATA_W must lie between 11 and 16");
	end

	// Parameter registers
	logic [1:0] func_reg;
	logic [1:0] src_reg;
	logic [DATA_W-1:0] tension_fitted_param_reg;
	logic [DATA_W-1:0] tension_stretched_param_reg;
	logic [DATA_W-1:0] friction_fitted_param_reg;
	logic [DATA_W-1:0] friction_stretched_param_reg;
	logic [DATA_W-1:0] tension_limit_param_reg;
	logic [btwc_pkg::IRQ_BITS-1:0] irq_status_reg;
	logic [btwc_pkg::IRQ_BITS-1:0] irq_mask_reg;
	logic [DATA_W-1:0] tension_est_reg;
	logic [15:0] reg_rdata_next;
	logic pred_enable_next;
	logic tension_bad;
	logic friction_bad;
	logic below_limit;
	logic [DATA_W+9:0] scaled_est;
	logic [2*DATA_W-1:0] scaled_limit;
	logic [DATA_W:0] friction_sum;
	logic [DATA_W-1:0] friction_basis_next;
	logic [btwc_pkg::IRQ_BITS-1:0] irq_events;
	logic wr_ctrl;

	assign wr_ctrl = reg_wr_in && (reg_addr_in == btwc_pkg::ADDR_CTRL);

	// Control fields
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			func_reg <= btwc_pkg::BTWC_FUNC_OFF;
			src_reg <= btwc_pkg::BTWC_SRC_FORWARD;
		end
		else if (wr_ctrl)
		begin
			func_reg <= reg_wdata_in[btwc_pkg::CTRL_FUNC_LSB +: 2];
			src_reg <= reg_wdata_in[btwc_pkg::CTRL_SRC_LSB +: 2];
		end
	end

	// Reference parameters, one register each, all zero after reset
	btwc_param_reg #(
		.WIDTH(DATA_W),
		.INDEX(btwc_pkg::ADDR_TENSION_FITTED)
	) i_tension_fitted (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.addr_in(reg_addr_in),
		.wdata_in(reg_wdata_in[DATA_W-1:0]),
		.wr_in(reg_wr_in),
		.value_out(tension_fitted_param_reg)
	);

	btwc_param_reg #(
		.WIDTH(DATA_W),
		.INDEX(btwc_pkg::ADDR_TENSION_STRETCHED)
	) i_tension_stretched (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.addr_in(reg_addr_in),
		.wdata_in(reg_wdata_in[DATA_W-1:0]),
		.wr_in(reg_wr_in),
		.value_out(tension_stretched_param_reg)
	);

	btwc_param_reg #(
		.WIDTH(DATA_W),
		.INDEX(btwc_pkg::ADDR_FRICTION_FITTED)
	) i_friction_fitted (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.addr_in(reg_addr_in),
		.wdata_in(reg_wdata_in[DATA_W-1:0]),
		.wr_in(reg_wr_in),
		.value_out(friction_fitted_param_reg)
	);

	btwc_param_reg #(
		.WIDTH(DATA_W),
		.INDEX(btwc_pkg::ADDR_FRICTION_STRETCHED)
	) i_friction_stretched (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.addr_in(reg_addr_in),
		.wdata_in(reg_wdata_in[DATA_W-1:0]),
		.wr_in(reg_wr_in),
		.value_out(friction_stretched_param_reg)
	);

	btwc_param_reg #(
		.WIDTH(DATA_W),
		.INDEX(btwc_pkg::ADDR_TENSION_LIMIT)
	) i_tension_limit (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.addr_in(reg_addr_in),
		.wdata_in(reg_wdata_in[DATA_W-1:0]),
		.wr_in(reg_wr_in),
		.value_out(tension_limit_param_reg)
	);

	// Interrupt mask
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			irq_mask_reg <= btwc_pkg::IRQ_RESET;
		else if (reg_wr_in && reg_addr_in == btwc_pkg::ADDR_IRQ_MASK)
			irq_mask_reg <= reg_wdata_in[btwc_pkg::IRQ_BITS-1:0];
	end

	// Consistency checks and enable decision
	always_comb
	begin
		tension_bad = tension_fitted_param_reg < tension_stretched_param_reg;
		friction_bad = friction_fitted_param_reg < friction_stretched_param_reg;
		pred_enable_next = (func_reg == btwc_pkg::BTWC_FUNC_PREDICT)
			&& !tension_bad && !friction_bad;
	end

	// Friction basis choice
	always_comb
	begin
		friction_sum = {1'b0, friction_fwd_in} + {1'b0, friction_rev_in};
		case (src_reg)
			btwc_pkg::BTWC_SRC_FORWARD: friction_basis_next = friction_fwd_in;
			btwc_pkg::BTWC_SRC_REVERSE: friction_basis_next = friction_rev_in;
			btwc_pkg::BTWC_SRC_AVERAGE: friction_basis_next = friction_sum[DATA_W:1];
			default: friction_basis_next = friction_fwd_in;
		endcase
	end

	// Limit test: est * 1000 < fitted * limit, avoids a divider
	always_comb
	begin
		scaled_est = tension_est_reg * btwc_pkg::PER_MILLE;
		scaled_limit = tension_fitted_param_reg * tension_limit_param_reg;
		below_limit = ({{(DATA_W-10){1'b0}}, scaled_est} < scaled_limit);
	end

	// Latest tension estimate
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			tension_est_reg <= btwc_pkg::PARAM_RESET[DATA_W-1:0];
		else if (tension_valid_in)
			tension_est_reg <= tension_est_in;
	end

	// Friction basis output, updated on each estimate
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			friction_basis_out <= btwc_pkg::PARAM_RESET[DATA_W-1:0];
		else if (friction_valid_in)
			friction_basis_out <= friction_basis_next;
	end

	// Enables towards the estimator and predictor
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			estimation_enable_out <= 1'b0;
			prediction_enable_out <= 1'b0;
		end
		else
		begin
			estimation_enable_out <= (func_reg != btwc_pkg::BTWC_FUNC_OFF);
			prediction_enable_out <= pred_enable_next;
		end
	end

	// Warning: raised below limit, dropped at or above it or when disabled
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			machine_diagnosis_warning_out <= 1'b0;
		else if (!pred_enable_next)
			machine_diagnosis_warning_out <= 1'b0;
		else
			machine_diagnosis_warning_out <= below_limit;
	end

	// Events: warning raised, warning cleared, references turned inconsistent
	always_comb
	begin
		irq_events = '0;
		irq_events[btwc_pkg::IRQ_WARN_SET_BIT] = pred_enable_next && below_limit
			&& !machine_diagnosis_warning_out;
		irq_events[btwc_pkg::IRQ_WARN_CLR_BIT] = machine_diagnosis_warning_out
			&& !(pred_enable_next && below_limit);
		irq_events[btwc_pkg::IRQ_CFG_BAD_BIT] = (func_reg == btwc_pkg::BTWC_FUNC_PREDICT)
			&& (tension_bad || friction_bad) && prediction_enable_out;
	end

	// Sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			irq_status_reg <= btwc_pkg::IRQ_RESET;
		else if (reg_wr_in && reg_addr_in == btwc_pkg::ADDR_IRQ_STATUS)
			irq_status_reg <= (irq_status_reg & ~reg_wdata_in[btwc_pkg::IRQ_BITS-1:0])
				| irq_events;
		else
			irq_status_reg <= irq_status_reg | irq_events;
	end

	// Level interrupt from registered status and mask
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			irq_out <= 1'b0;
		else
			irq_out <= |(irq_status_reg & irq_mask_reg);
	end

	// Read multiplexer; unmapped indices read zero
	always_comb
	begin
		reg_rdata_next = 16'h0000;
		if (reg_addr_in == btwc_pkg::ADDR_CTRL)
		begin
			reg_rdata_next[btwc_pkg::CTRL_FUNC_LSB +: 2] = func_reg;
			reg_rdata_next[btwc_pkg::CTRL_SRC_LSB +: 2] = src_reg;
		end
		else if (reg_addr_in == btwc_pkg::ADDR_TENSION_FITTED)
			reg_rdata_next[DATA_W-1:0] = tension_fitted_param_reg;
		else if (reg_addr_in == btwc_pkg::ADDR_TENSION_STRETCHED)
			reg_rdata_next[DATA_W-1:0] = tension_stretched_param_reg;
		else if (reg_addr_in == btwc_pkg::ADDR_FRICTION_FITTED)
			reg_rdata_next[DATA_W-1:0] = friction_fitted_param_reg;
		else if (reg_addr_in == btwc_pkg::ADDR_FRICTION_STRETCHED)
			reg_rdata_next[DATA_W-1:0] = friction_stretched_param_reg;
		else if (reg_addr_in == btwc_pkg::ADDR_TENSION_LIMIT)
			reg_rdata_next[DATA_W-1:0] = tension_limit_param_reg;
		else if (reg_addr_in == btwc_pkg::ADDR_IRQ_STATUS)
			reg_rdata_next[btwc_pkg::IRQ_BITS-1:0] = irq_status_reg;
		else if (reg_addr_in == btwc_pkg::ADDR_IRQ_MASK)
			reg_rdata_next[btwc_pkg::IRQ_BITS-1:0] = irq_mask_reg;
		else if (reg_addr_in == btwc_pkg::ADDR_STATE)
		begin
			reg_rdata_next[btwc_pkg::STATE_PRED_BIT] = prediction_enable_out;
			reg_rdata_next[btwc_pkg::STATE_EST_BIT] = estimation_enable_out;
			reg_rdata_next[btwc_pkg::STATE_WARN_BIT] = machine_diagnosis_warning_out;
			reg_rdata_next[btwc_pkg::STATE_TENS_BAD_BIT] = tension_bad;
			reg_rdata_next[btwc_pkg::STATE_FRIC_BAD_BIT] = friction_bad;
		end
		else if (reg_addr_in == btwc_pkg::ADDR_TENSION_EST)
			reg_rdata_next[DATA_W-1:0] = tension_est_reg;
		else if (reg_addr_in == btwc_pkg::ADDR_FRICTION_BASIS)
			reg_rdata_next[DATA_W-1:0] = friction_basis_out;
	end

	// Read data stands only in the cycle after the read strobe
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			reg_rdata_out <= 16'h0000;
		else if (reg_rd_in)
			reg_rdata_out <= reg_rdata_next;
		else
			reg_rdata_out <= 16'h0000;
	end

endmodule : btwc_top

`default_nettype wire

// file: btwc_top_monitor.sv
/* Assertions for btwc_top, seen from its ports only.
 * Assumes the one-cycle strobe register port of the block. */
`timescale 1ns/1ps
`default_nettype none
module btwc_monitor #(
	parameter int DATA_W = 16
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// Register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [15:0] reg_rdata_out,
	// Estimators
	input wire logic [DATA_W-1:0] friction_fwd_in,
	input wire logic [DATA_W-1:0] friction_rev_in,
	input wire logic friction_valid_in,
	input wire logic [DATA_W-1:0] tension_est_in,
	input wire logic tension_valid_in,
	// Status
	input wire logic estimation_enable_out,
	input wire logic prediction_enable_out,
	input wire logic [DATA_W-1:0] friction_basis_out,
	input wire logic machine_diagnosis_warning_out,
	input wire logic irq_out
);
	logic [15:0] ctrl_q;
	logic [DATA_W-1:0] tf_q, ts_q, ff_q, fs_q, lim_q;
	logic [DATA_W-1:0] est_q;
	logic pred_ok, warn_ok;
	// Mirror of the written configuration
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			{ctrl_q, tf_q, ts_q, ff_q, fs_q, lim_q} <= '0;
		else if (reg_wr_in)
		begin
			case (reg_addr_in)
				btwc_pkg::ADDR_CTRL: ctrl_q <= reg_wdata_in;
				btwc_pkg::ADDR_TENSION_FITTED: tf_q <= reg_wdata_in[DATA_W-1:0];
				btwc_pkg::ADDR_TENSION_STRETCHED: ts_q <= reg_wdata_in[DATA_W-1:0];
				btwc_pkg::ADDR_FRICTION_FITTED: ff_q <= reg_wdata_in[DATA_W-1:0];
				btwc_pkg::ADDR_FRICTION_STRETCHED: fs_q <= reg_wdata_in[DATA_W-1:0];
				btwc_pkg::ADDR_TENSION_LIMIT: lim_q <= reg_wdata_in[DATA_W-1:0];
				default: ;
			endcase
		end
	end
	// Latest tension estimate
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			est_q <= '0;
		else if (tension_valid_in)
			est_q <= tension_est_in;
	end
	// Expected enables from the mirror
	assign pred_ok = ctrl_q[1:0] == 2'h2 && tf_q >= ts_q && ff_q >= fs_q;
	assign warn_ok = pred_ok && lim_q != '0 && 32'(est_q) * 32'h3E8 < 32'(tf_q) * 32'(lim_q);
	// Selected friction for a source code
	function automatic logic [DATA_W-1:0] sel(input logic [1:0] s,
		input logic [DATA_W-1:0] f, input logic [DATA_W-1:0] r);
		if (s == 2'h1)
			return r;
		if (s == 2'h2)
			return DATA_W'(({1'b0, f} + {1'b0, r}) >> 1);
		return f;
	endfunction : sel
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0)
		else $error("read data outside a read answer");
	pred_value_a: assert property (prediction_enable_out == $past(pred_ok))
		else $error("prediction enable wrong");
	est_value_a: assert property (estimation_enable_out == $past(ctrl_q[1:0] != 2'h0))
		else $error("estimation enable wrong");
	pred_chain_a: assert property (prediction_enable_out |-> estimation_enable_out)
		else $error("prediction without estimation");
	warn_value_a: assert property (machine_diagnosis_warning_out == $past(warn_ok))
		else $error("warning wrong");
	warn_gate_a: assert property (machine_diagnosis_warning_out |-> prediction_enable_out)
		else $error("warning while disabled");
	basis_sel_a: assert property (friction_valid_in |=>
		friction_basis_out == sel($past(ctrl_q[5:4]),
		$past(friction_fwd_in), $past(friction_rev_in)))
		else $error("friction basis wrong");
	basis_hold_a: assert property (!$past(friction_valid_in) |-> $stable(friction_basis_out))
		else $error("friction basis moved");
	// Main scenarios
	cover property ($rose(prediction_enable_out));
	cover property ($rose(machine_diagnosis_warning_out));
	cover property ($rose(irq_out));
endmodule : btwc_monitor
bind btwc_top btwc_monitor #(.DATA_W(DATA_W)) i_mon (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .friction_fwd_in(friction_fwd_in),
	.friction_rev_in(friction_rev_in), .friction_valid_in(friction_valid_in),
	.tension_est_in(tension_est_in), .tension_valid_in(tension_valid_in),
	.estimation_enable_out(estimation_enable_out), .prediction_enable_out(prediction_enable_out),
	.friction_basis_out(friction_basis_out), .irq_out(irq_out),
	.machine_diagnosis_warning_out(machine_diagnosis_warning_out));
`default_nettype wire

// file: tb_belt_tension_wear_check.sv
/* Self-checking bench for btwc_top.
 * Drives the register port and estimator inputs directly. */
`timescale 1ns/1ps
`default_nettype none
module tb_belt_tension_wear_check;
	logic mclk_in, rst_n_in, reg_wr_in, reg_rd_in, friction_valid_in, tension_valid_in;
	logic estimation_enable_out, prediction_enable_out, machine_diagnosis_warning_out, irq_out;
	logic [3:0] reg_addr_in;
	logic [15:0] reg_wdata_in, reg_rdata_out, friction_fwd_in, friction_rev_in;
	logic [15:0] tension_est_in, friction_basis_out;
	logic [15:0] cfg [4] = '{16'h03E8, 16'h01F4, 16'h012C, 16'h00C8};
	logic [15:0] bexp [4] = '{16'h0064, 16'h0033, 16'h004B, 16'h0064};
	int err_count = 0;
	int samples_checked = 0;
	btwc_top #(.DATA_W(16)) i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .friction_fwd_in(friction_fwd_in),
		.friction_rev_in(friction_rev_in), .friction_valid_in(friction_valid_in),
		.tension_est_in(tension_est_in), .tension_valid_in(tension_valid_in),
		.estimation_enable_out(estimation_enable_out), .prediction_enable_out(prediction_enable_out),
		.friction_basis_out(friction_basis_out), .irq_out(irq_out),
		.machine_diagnosis_warning_out(machine_diagnosis_warning_out));
	// 40 MHz clock
	initial
	begin
		mclk_in = 1'b0;
		forever #12.5 mclk_in = ~mclk_in;
	end
	task final_report;
		if (err_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task chk1(input logic got, input logic exp);
		chk({15'h0, got}, {15'h0, exp});
	endtask : chk1
	task wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge mclk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= v;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
	endtask : wr
	task rdc(input logic [3:0] a, input logic [15:0] exp);
		@(posedge mclk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge mclk_in);
		reg_rd_in <= 1'b0;
		#1 chk(reg_rdata_out, exp);
	endtask : rdc
	task tv(input logic [15:0] e);
		@(posedge mclk_in);
		tension_valid_in <= 1'b1;
		tension_est_in <= e;
		@(posedge mclk_in);
		tension_valid_in <= 1'b0;
	endtask : tv
	task settle;
		repeat (4) @(posedge mclk_in);
		#1;
	endtask : settle
	// Hang guard
	initial
	begin
		#500000;
		err_count++;
		final_report;
	end
	// Main sequence
	initial
	begin
		{rst_n_in, reg_wr_in, reg_rd_in, friction_valid_in, tension_valid_in} = '0;
		{reg_addr_in, reg_wdata_in, friction_fwd_in, friction_rev_in, tension_est_in} = '0;
		repeat (12) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		for (int i = 0; i < 16; i++) rdc(4'(i), 16'h0);
		// Tension fitted 1000 over stretched 500, friction fitted 300 over stretched 200
		for (int i = 0; i < 4; i++) wr(4'(i + 1), cfg[i]);
		for (int i = 0; i < 4; i++) rdc(4'(i + 1), cfg[i]);
		wr(4'h8, 16'hFFFF);
		rdc(4'h8, 16'h0);
		wr(4'h7, 16'h0007);
		for (int f = 0; f < 4; f++)
		begin
			wr(4'h0, 16'(f));
			settle;
			chk1(estimation_enable_out, f != 0);
			chk1(prediction_enable_out, f == 2);
		end
		for (int s = 0; s < 4; s++)
		begin
			wr(4'h0, 16'(s * 16 + 2));
			@(posedge mclk_in);
			friction_valid_in <= 1'b1;
			friction_fwd_in <= 16'h0064;
			friction_rev_in <= 16'h0033;
			@(posedge mclk_in);
			friction_valid_in <= 1'b0;
			settle;
			chk(friction_basis_out, bexp[s]);
		end
		wr(4'h6, 16'h0007);
		wr(4'h2, 16'h03E9);
		settle;
		chk1(prediction_enable_out, 1'b0);
		chk1(irq_out, 1'b1);
		rdc(4'h6, 16'h0004);
		rdc(4'h8, 16'h000A);
		wr(4'h7, 16'h0000);
		settle;
		chk1(irq_out, 1'b0);
		wr(4'h6, 16'h0004);
		rdc(4'h6, 16'h0000);
		wr(4'h7, 16'h0007);
		wr(4'h2, 16'h03E8);
		settle;
		chk1(prediction_enable_out, 1'b1);
		wr(4'h3, 16'h00C7);
		settle;
		chk1(prediction_enable_out, 1'b0);
		rdc(4'h8, 16'h0012);
		wr(4'h3, 16'h012C);
		tv(16'h01F4);
		wr(4'h6, 16'h0007);
		wr(4'h5, 16'h01F4);
		settle;
		chk1(machine_diagnosis_warning_out, 1'b0);
		tv(16'h01F3);
		settle;
		chk1(machine_diagnosis_warning_out, 1'b1);
		chk1(irq_out, 1'b1);
		rdc(4'h6, 16'h0001);
		rdc(4'h9, 16'h01F3);
		wr(4'h2, 16'h01F4);
		wr(4'h1, 16'h03E6);
		settle;
		chk1(machine_diagnosis_warning_out, 1'b0);
		rdc(4'h6, 16'h0003);
		wr(4'h1, 16'h03E8);
		wr(4'h0, 16'h0001);
		settle;
		chk1(machine_diagnosis_warning_out, 1'b0);
		wr(4'h0, 16'h0002);
		settle;
		chk1(machine_diagnosis_warning_out, 1'b1);
		wr(4'h5, 16'h0000);
		settle;
		chk1(machine_diagnosis_warning_out, 1'b0);
		final_report;
	end
endmodule : tb_belt_tension_wear_check
`default_nettype wire
